// ==== rtl/wb_fn_pkg.sv ====
// Constants and types for the hard-function register slave
package wb_fn_pkg;

	// ========================================================
	// Bus widths
	localparam int ADR_W = 8;
	localparam int DAT_W = 8;
	localparam int MEM_DEPTH = 256;

	// ========================================================
	// Clock and reset timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int CLK_MAX_MHZ = 133;
	localparam int RST_WAIT_NS = 1000;
	localparam int RST_WAIT_CYC =
		(RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ========================================================
	// Window bounds, inclusive
	localparam logic [7:0] PLLA_LO = 8'h00;
	localparam logic [7:0] PLLA_HI = 8'h1F;
	localparam logic [7:0] PLLB_LO = 8'h20;
	localparam logic [7:0] PLLB_HI = 8'h3F;
	localparam logic [7:0] I2CP_LO = 8'h40;
	localparam logic [7:0] I2CP_HI = 8'h49;
	localparam logic [7:0] I2CS_LO = 8'h4A;
	localparam logic [7:0] I2CS_HI = 8'h53;
	localparam logic [7:0] SPI_LO = 8'h54;
	localparam logic [7:0] SPI_HI = 8'h5D;
	localparam logic [7:0] TMR_LO = 8'h5E;
	localparam logic [7:0] TMR_HI = 8'h6F;
	localparam logic [7:0] FLASH_LO = 8'h70;
	localparam logic [7:0] FLASH_HI = 8'h75;
	localparam logic [7:0] IRQ_LO = 8'h76;
	localparam logic [7:0] IRQ_HI = 8'h77;

	// ========================================================
	// Control fields watched by the run logic
	localparam logic [7:0] PRIMARY_I2C_CONTROL_REG = 8'h40;
	localparam int I2C_DLY_LSB = 2;
	localparam logic [1:0] I2C_DLY_OFF = 2'h3;
	localparam logic [7:0] TMR_CTRL_REG = 8'h5E;
	localparam int TMR_USER_CLK_BIT = 0;

	// ========================================================
	// Reset values of the interface logic, and the unmapped read value
	localparam logic [7:0] DAT_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
	localparam logic [7:0] WIN_RST = 8'h00;
	localparam logic [7:0] RUN_RST = 8'h00;

	// ========================================================
	// Windows, in the bit order of the one-hot outputs
	typedef enum {
		WIN_PLLA,
		WIN_PLLB,
		WIN_I2CP,
		WIN_I2CS,
		WIN_SPI,
		WIN_TMR,
		WIN_FLASH,
		WIN_IRQ,
		WIN_NONE
	} win_t;
	localparam int WIN_COUNT = 8;

	typedef enum {
		ST_IDLE,
		ST_ACK,
		ST_WAIT
	} bus_state_t;

endpackage

// ==== rtl/wb_fn_slave.sv ====
// Byte-wide register slave fronting the embedded hard-function block
//
// What this block does
// - Everything runs on rising edge of clock.
// - Reset clears interface only, registers keep contents.
// - Reset during a cycle aborts it, no ack.
// - Strobe within valid cycle gets an acknowledge.
// - Write enable low reads, high writes.
// - Eight-bit address selects one byte register inside the windows, none outside them.
// - Write data byte stored at addressed register.
// - Read returns addressed register on read data.
// - Acknowledge means write accepted or read valid.
// - Addresses 00 to 1F reach first PLL.
// - Addresses 20 to 3F reach second PLL.
// - Remaining windows decoded: I2C, SPI, timer, flash, irq.
// - Each function owns byte registers in its window.
// - Flash and configuration share one register set.
// - Any access port reaches every register.
// - Oscillator off: only SPI, gated I2C, user-clock timer.
module wb_fn_slave
	import wb_fn_pkg::*;
#(
	parameter bit HAS_SECOND_PLL = 1'b1
) (
	input  wire logic             i_clk,
	input  wire logic             i_rstn,
	input  wire logic             i_cyc,
	input  wire logic             i_stb,
	input  wire logic             i_we,
	input  wire logic [ADR_W-1:0] i_adr,
	input  wire logic [DAT_W-1:0] i_dat,
	input  wire logic             i_oscillator_off,
	output logic                  o_ack,
	output logic      [DAT_W-1:0] o_dat,
	output logic  [WIN_COUNT-1:0] o_win_sel,
	output logic  [WIN_COUNT-1:0] o_func_run
);

	// ========================================================
	// Address decode
	function automatic win_t window_of(input logic [7:0] adr);
		win_t w;
		w = WIN_NONE;
		if (adr >= PLLA_LO && adr <= PLLA_HI) begin
			w = WIN_PLLA;
		end else if (adr >= PLLB_LO && adr <= PLLB_HI) begin
			w = HAS_SECOND_PLL ? WIN_PLLB : WIN_NONE;
		end else if (adr >= I2CP_LO && adr <= I2CP_HI) begin
			w = WIN_I2CP;
		end else if (adr >= I2CS_LO && adr <= I2CS_HI) begin
			w = WIN_I2CS;
		end else if (adr >= SPI_LO && adr <= SPI_HI) begin
			w = WIN_SPI;
		end else if (adr >= TMR_LO && adr <= TMR_HI) begin
			w = WIN_TMR;
		end else if (adr >= FLASH_LO && adr <= FLASH_HI) begin
			w = WIN_FLASH;
		end else if (adr >= IRQ_LO && adr <= IRQ_HI) begin
			w = WIN_IRQ;
		end
		return w;
	endfunction

	function automatic logic [WIN_COUNT-1:0] onehot_of(input win_t w);
		logic [WIN_COUNT-1:0] v;
		v = '0;
		if (w != WIN_NONE) begin
			v[int'(w)] = 1'b1;
		end
		return v;
	endfunction

	// ========================================================
	// Storage
	// Flash and configuration share the one flash window
	logic [DAT_W-1:0] mem [MEM_DEPTH];

	bus_state_t           state_reg;
	bus_state_t           state_next;
	logic                 ack_reg;
	logic     [DAT_W-1:0] dat_reg;
	logic [WIN_COUNT-1:0] win_reg;
	logic [WIN_COUNT-1:0] run_reg;
	logic [WIN_COUNT-1:0] run_next;
	logic                 oscillator_meta_reg;
	logic                 oscillator_off_reg;
	logic                 take;
	logic                 req_mapped;
	win_t                 req_win;

	assign req_win = window_of(i_adr);
	assign req_mapped = (req_win != WIN_NONE);
	assign take = (state_reg == ST_IDLE) && i_cyc && i_stb;

	// ========================================================
	// Handshake
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (take) begin
					state_next = ST_ACK;
				end
			end
			ST_ACK: begin
				// Strobe still high: hold off until it drops
				state_next = (i_cyc && i_stb) ? ST_WAIT : ST_IDLE;
			end
			ST_WAIT: begin
				if (!(i_cyc && i_stb)) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= take;
		end
	end

	// ========================================================
	// Register file, deliberately without reset
	always_ff @(posedge i_clk) begin
		if (i_rstn && take && i_we && req_mapped) begin
			mem[i_adr] <= i_dat;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			dat_reg <= DAT_RST;
		end else if (take && !i_we) begin
			dat_reg <= req_mapped ? mem[i_adr] : UNMAPPED_RD;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			win_reg <= WIN_RST;
		end else if (take) begin
			win_reg <= onehot_of(req_win);
		end
	end

	// ========================================================
	// Oscillator status, crossed from outside
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			oscillator_meta_reg <= 1'b0;
			oscillator_off_reg <= 1'b0;
		end else begin
			oscillator_meta_reg <= i_oscillator_off;
			oscillator_off_reg <= oscillator_meta_reg;
		end
	end

	// ========================================================
	// Which functions may run
	always_comb begin
		logic [1:0] dly;
		logic       user_clk;
		dly = mem[PRIMARY_I2C_CONTROL_REG][I2C_DLY_LSB +: 2];
		user_clk = mem[TMR_CTRL_REG][TMR_USER_CLK_BIT];
		run_next = '1;
		run_next[int'(WIN_PLLB)] = HAS_SECOND_PLL;
		if (oscillator_off_reg) begin
			// Flash, PLL and interrupt logic need the oscillator
			run_next = '0;
			run_next[int'(WIN_SPI)] = 1'b1;
			run_next[int'(WIN_I2CP)] = (dly == I2C_DLY_OFF);
			run_next[int'(WIN_I2CS)] = (dly == I2C_DLY_OFF);
			run_next[int'(WIN_TMR)] = user_clk;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			run_reg <= RUN_RST;
		end else begin
			run_reg <= run_next;
		end
	end

	assign o_ack = ack_reg;
	assign o_dat = dat_reg;
	assign o_win_sel = win_reg;
	assign o_func_run = run_reg;

	// ========================================================
	// Checks
	logic [ADR_W-1:0] last_adr_reg;
	logic             last_we_reg;
	logic             last_map_reg;
	logic [DAT_W-1:0] last_dat_reg;

	always_ff @(posedge i_clk) begin
		if (take) begin
			last_adr_reg <= i_adr;
			last_we_reg <= i_we;
			last_map_reg <= req_mapped;
			last_dat_reg <= i_dat;
		end
	end

	a_ack_one_cycle: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		o_ack |=> !o_ack
	) else $error("ack held longer than one cycle");

	a_ack_has_cause: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_ack) |-> $past(i_cyc) && $past(i_stb)
	) else $error("ack without a valid strobe");

	a_strobe_answered: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		(state_reg == ST_IDLE) && i_cyc && i_stb |=> o_ack
	) else $error("strobe not acknowledged next cycle");

	a_fresh_strobe: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		o_ack && i_cyc && i_stb ##1 i_cyc && i_stb |=> !o_ack
	) else $error("ack repeated on an unbroken strobe");

	a_reset_abort: assert property (
		@(posedge i_clk)
		!i_rstn |=> !o_ack && o_dat == DAT_RST
	) else $error("ack or data after reset");

	a_write_stored: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		o_ack && last_we_reg && last_map_reg |->
			mem[last_adr_reg] == last_dat_reg
	) else $error("write data not stored");

	a_read_value: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		o_ack && !last_we_reg |->
			o_dat == (last_map_reg ? mem[last_adr_reg] : UNMAPPED_RD)
	) else $error("read data does not match register");

	a_window_onehot: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		o_ack |-> $onehot0(o_win_sel) &&
			((o_win_sel != '0) == last_map_reg)
	) else $error("window select not one-hot");

	a_pll_window: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		take && i_adr <= PLLA_HI |=> o_win_sel[int'(WIN_PLLA)]
	) else $error("low addresses missed first PLL");

	a_clock_off_gate: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		oscillator_off_reg ##1 oscillator_off_reg |->
			!o_func_run[int'(WIN_FLASH)] && !o_func_run[int'(WIN_PLLA)]
			&& o_func_run[int'(WIN_SPI)]
	) else $error("function runs without oscillator");

	a_read_data_holds: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		$past(i_rstn) && !($past(take) && !$past(i_we)) |-> $stable(o_dat)
	) else $error("read data changed without a read");

	a_window_holds: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		$past(i_rstn) && !$past(take) |-> $stable(o_win_sel)
	) else $error("window select changed without an access");

	a_unmapped_read: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		take && !i_we && !req_mapped |=> o_dat == UNMAPPED_RD
	) else $error("unmapped read returned data");

	a_write_keeps_read: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		take && i_we |=> $stable(o_dat)
	) else $error("write disturbed read data");

	a_second_pll_window: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		take && i_adr >= PLLB_LO && i_adr <= PLLB_HI |=>
			o_win_sel[int'(WIN_PLLB)] == HAS_SECOND_PLL
	) else $error("second PLL window decoded wrongly");

	a_second_pll_absent: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		!HAS_SECOND_PLL |-> !o_func_run[int'(WIN_PLLB)]
	) else $error("missing second PLL marked as running");

	a_flash_window: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		take && i_adr >= FLASH_LO && i_adr <= FLASH_HI |=>
			o_win_sel[int'(WIN_FLASH)]
	) else $error("flash window decoded wrongly");

	a_spi_window: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		take && i_adr >= SPI_LO && i_adr <= SPI_HI |=>
			o_win_sel[int'(WIN_SPI)]
	) else $error("SPI window decoded wrongly");

	a_run_with_clock: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		!oscillator_off_reg |=> o_func_run[int'(WIN_SPI)] &&
			o_func_run[int'(WIN_FLASH)] && o_func_run[int'(WIN_PLLA)]
	) else $error("function stopped with oscillator running");

	a_i2c_pair_gate: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		o_func_run[int'(WIN_I2CP)] == o_func_run[int'(WIN_I2CS)]
	) else $error("the two I2C cores gated differently");

	a_reset_clears_out: assert property (
		@(posedge i_clk)
		!i_rstn |=> o_win_sel == WIN_RST && o_func_run == RUN_RST
	) else $error("window or run flags kept over reset");

	a_wait_no_ack: assert property (
		@(posedge i_clk) disable iff (!i_rstn)
		state_reg == ST_WAIT |=> !o_ack
	) else $error("ack while waiting for strobe to drop");

endmodule

// ==== tb/wb_master_model.sv ====
// Behavioural WISHBONE master facing the hard-function slave
module wb_master_model (
	input  wire logic       i_clk,
	input  wire logic       i_ack,
	input  wire logic [7:0] i_dat,
	output logic            o_cyc,
	output logic            o_stb,
	output logic            o_we,
	output logic      [7:0] o_adr,
	output logic      [7:0] o_dat
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		o_cyc = 1'b0;
		o_stb = 1'b0;
		o_we = 1'b0;
		o_adr = 8'hA5;
		o_dat = 8'h5A;
	end

	// ==========================================================
	// One access; hold keeps the strobe up past the acknowledge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, input int hold,
		output logic [7:0] r, output logic ok, output int extra);
		ok = 1'b0;
		extra = 0;
		r = 8'h00;
		@(negedge i_clk);
		o_cyc <= 1'b1;
		o_stb <= 1'b1;
		o_we <= w;
		o_adr <= a;
		o_dat <= d;
		for (int k = 0; k < 8 && ok !== 1'b1; k++) begin
			@(posedge i_clk);
			if (i_ack === 1'b1) begin
				ok = 1'b1;
				r = i_dat;
			end
		end
		repeat (hold) begin
			@(posedge i_clk);
			if (i_ack === 1'b1) begin
				extra++;
			end
		end
		@(negedge i_clk);
		o_cyc <= 1'b0;
		o_stb <= 1'b0;
		// Released lines flip so stale values never look valid
		o_we <= ~w;
		o_adr <= ~a;
		o_dat <= ~d;
	endtask
endmodule

// ==== tb/wishbone_function_block_slave_test.sv ====
// Self-checking bench for the hard-function register slave
module wishbone_function_block_slave_test
	import wb_fn_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic       clk;
	logic       rstn = 1'b0;
	logic       clk_off = 1'b0;
	logic       cyc, stb, we, ack;
	logic [7:0] adr, wdat, rdat, win, run;
	logic       ack_single;
	logic [7:0] rdat_single, win_single, run_single;
	int         n_mismatch = 0;
	int         n_tests = 0;
	int         cycles = 0;

	wb_fn_slave i_wb_fn_slave (.i_clk(clk), .i_rstn(rstn), .i_cyc(cyc),
		.i_stb(stb), .i_we(we), .i_adr(adr), .i_dat(wdat),
		.i_oscillator_off(clk_off), .o_ack(ack), .o_dat(rdat),
		.o_win_sel(win), .o_func_run(run));
	// Variant without the second PLL, fed the same bus
	wb_fn_slave #(.HAS_SECOND_PLL(1'b0)) i_wb_fn_slave_single (.i_clk(clk),
		.i_rstn(rstn), .i_cyc(cyc), .i_stb(stb), .i_we(we), .i_adr(adr),
		.i_dat(wdat), .i_oscillator_off(clk_off),
		.o_ack(ack_single), .o_dat(rdat_single), .o_win_sel(win_single),
		.o_func_run(run_single));
	// Sole master, so it owns the bus without an arbiter
	wb_master_model i_wb_master_model (.i_clk(clk), .i_ack(ack),
		.i_dat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(we),
		.o_adr(adr), .o_dat(wdat));

	// ==========================================================
	// Clock and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ==========================================================
	// Expectations
	function automatic logic [7:0] win_exp(logic [7:0] a, logic two);
		if (a <= PLLA_HI) return 8'h01;
		if (a <= PLLB_HI) return two ? 8'h02 : 8'h00;
		if (a <= I2CP_HI) return 8'h04;
		if (a <= I2CS_HI) return 8'h08;
		if (a <= SPI_HI) return 8'h10;
		if (a <= TMR_HI) return 8'h20;
		if (a <= FLASH_HI) return 8'h40;
		if (a <= IRQ_HI) return 8'h80;
		return 8'h00;
	endfunction

	function automatic logic [7:0] run_exp(logic o, logic [7:0] c40,
		logic [7:0] c5e, logic two);
		logic [7:0] r;
		if (!o) return two ? 8'hFF : 8'hFD;
		r = 8'h10;
		if (c40[3:2] == 2'h3) r = r | 8'h0C;
		if (c5e[0]) r = r | 8'h20;
		return r;
	endfunction

	// ==========================================================
	// Shared tasks
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] r);
		logic ok;
		int   ex;
		i_wb_master_model.xfer(w, a, d, 0, r, ok, ex);
		chk({7'h00, ok}, 8'h01);
	endtask

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [7:0] a, d, r, c40, c5e, e;
		logic [7:0] adrs[$];
		logic       ok;
		int         ex;
		void'($urandom(69));
		repeat (10) @(negedge clk);
		chk({7'h00, ack}, 8'h00);
		chk(rdat, DAT_RST);
		chk(win, WIN_RST);
		chk(run, RUN_RST);
		chk(win_single, WIN_RST);
		rstn = 1'b1;
		// Master keeps quiet for the settling time after reset
		repeat (RST_WAIT_CYC) @(negedge clk);
		$display("Test reset done");

		adrs = '{8'h00, 8'h1F, 8'h20, 8'h3F, 8'h40, 8'h49, 8'h4A,
			8'h53, 8'h54, 8'h5D, 8'h5E, 8'h6F, 8'h70, 8'h75, 8'h76,
			8'h77, 8'h78, 8'hFF};
		repeat (14) adrs.push_back(8'($urandom));
		foreach (adrs[i]) begin
			a = adrs[i];
			d = 8'($urandom);
			acc(1'b1, a, d, r);
			chk(win, win_exp(a, 1'b1));
			chk(win_single, win_exp(a, 1'b0));
			acc(1'b0, a, 8'h00, r);
			e = win_exp(a, 1'b1) != 8'h00 ? d : UNMAPPED_RD;
			chk(r, e);
			e = win_exp(a, 1'b0) != 8'h00 ? d : UNMAPPED_RD;
			chk(rdat_single, e);
			chk(win, win_exp(a, 1'b1));
		end
		$display("Test map done");

		i_wb_master_model.xfer(1'b0, 8'h54, 8'h00, 4, r, ok, ex);
		chk({7'h00, ok}, 8'h01);
		chk(8'(ex), 8'h00);
		$display("Test strobe hold done");

		acc(1'b1, 8'h10, 8'h55, r);
		fork
			i_wb_master_model.xfer(1'b1, 8'h10, 8'hAA, 0, r, ok, ex);
			begin
				@(negedge clk);
				rstn = 1'b0;
			end
		join
		chk({7'h00, ok}, 8'h00);
		chk(rdat, DAT_RST);
		rstn = 1'b1;
		repeat (RST_WAIT_CYC) @(negedge clk);
		acc(1'b0, 8'h10, 8'h00, r);
		chk(r, 8'h55);
		$display("Test abort done");

		for (int i = 0; i < 8; i++) begin
			clk_off = i[0];
			c40 = i < 2 ? 8'h0C : (i < 4 ? 8'h08 : 8'($urandom));
			c5e = i < 2 ? 8'h01 : (i < 4 ? 8'h00 : 8'($urandom));
			// Oscillator status passes a two-stage synchroniser
			repeat (4) @(negedge clk);
			acc(1'b1, PRIMARY_I2C_CONTROL_REG, c40, r);
			acc(1'b1, TMR_CTRL_REG, c5e, r);
			repeat (3) @(negedge clk);
			chk(run, run_exp(clk_off, c40, c5e, 1'b1));
			chk(run_single, run_exp(clk_off, c40, c5e, 1'b0));
		end
		$display("Test oscillator done");
		stop_test();
	end
endmodule
